// [fpl_loader.v]
// Purpose: device side of the fast parallel configuration load
// Assumes: load_clock sampled by ref_clk; 100 MHz ref_clk
// Notes:   status and completion are open-drain: oe high pulls low
//
// Contract
// - within 600 ns of request low, pull completion and status low.
// - status low between 268 and 1506 us unless held outside.
// - release status within 1506 us after request returns high.
// - capture each data word on a rising load clock edge.
// - with no decompression or security, one word per rising edge.
// - in user mode all lines high; request low restarts; the code drives startup-finished low if its option bit is set.
// - after power-up keep status low for the power-on delay.
// - completion low from power-up until loading succeeds.
// - load clock ignored once configuration completes; the code still needs two falling edges after completion before user mode.
// - completion released only after the whole image is received.
// - user mode between 175 and 437 us after completion rises.
// - startup-finished pin driven low when its option bit loaded; the code drives it low only from user-mode entry.
`timescale 1ns/1ns
`include "fpl_regs.vh"
module fpl_loader #(
    parameter STAT_CYC = `FPL_T_STAT_MIN_CYC,
    parameter UM_CYC   = `FPL_T_UM_MIN_CYC
)(
    // clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // link pins
    input  wire        reconfig_req_n,
    input  wire        load_clock,
    input  wire [31:0] load_data,
    input  wire        load_status_low_in,
    output reg         load_status_low_out,
    output reg         load_status_low_oe,
    input  wire        load_complete_flag_in,
    output reg         load_complete_flag_out,
    output reg         load_complete_flag_oe,
    output reg         init_done_out,
    output reg         init_done_oe,
    // configuration
    input  wire [1:0]  bus_width,
    input  wire [7:0]  word_ratio,
    input  wire [31:0] image_words,
    // status
    output reg         user_mode,
    output reg         load_error,
    output reg  [31:0] word_count,
    output reg  [31:0] cfg_word,
    output reg         cfg_word_valid
);
    localparam S_POR  = 5'b00001;
    localparam S_CLR  = 5'b00010;
    localparam S_LOAD = 5'b00100;
    localparam S_DONE = 5'b01000;
    localparam S_USER = 5'b10000;

    wire [19:0] stat_cyc = STAT_CYC[19:0];
    wire [19:0] um_cyc   = UM_CYC[19:0];

    reg  r1_ff;
    reg  rst_n;
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r1_ff <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            r1_ff <= 1'b1;
            rst_n <= r1_ff;
        end
    end

    // pins from outside the clock domain
    wire [35:0] sync_q;
    fpl_sync #(.W(36)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       ({load_data, reconfig_req_n, load_clock,
                   load_status_low_in, load_complete_flag_in}),
        .q       (sync_q)
    );
    wire [31:0] data_s = sync_q[35:4];
    wire        req_s  = sync_q[3];
    wire        clk_s  = sync_q[2];
    wire        stat_s = sync_q[1];
    wire        done_s = sync_q[0];

    reg         clk_d_ff;
    reg  [4:0]  state_ff;
    reg  [19:0] tmr_ff;
    reg  [7:0]  rep_ff;
    reg  [1:0]  fall_ff;
    reg         opt_ff;
    wire        rise = clk_s & ~clk_d_ff;
    wire        fall = ~clk_s & clk_d_ff;
    // data sampled in the same pipeline stage as the clock edge
    wire [7:0]  ratio = (word_ratio == 8'h00) ? `FPL_RATIO_DEF : word_ratio;
    // x8 and x16 keep the low lanes; other codes load all 32 bits
    wire [31:0] word_in =
        (bus_width == `FPL_WIDTH_X8)  ? {24'h000000, data_s[7:0]} :
        (bus_width == `FPL_WIDTH_X16) ? {16'h0000, data_s[15:0]} :
        data_s;
    wire        last_rep = (rep_ff + 8'h01 >= ratio);

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff               <= S_POR;
            tmr_ff                 <= 20'h00000;
            rep_ff                 <= 8'h00;
            fall_ff                <= 2'h0;
            opt_ff                 <= 1'b0;
            clk_d_ff               <= 1'b0;
            load_status_low_out    <= 1'b0;
            load_status_low_oe     <= 1'b1;
            load_complete_flag_out <= 1'b0;
            load_complete_flag_oe  <= 1'b1;
            init_done_out          <= 1'b0;
            init_done_oe           <= 1'b0;
            user_mode              <= 1'b0;
            load_error             <= 1'b0;
            word_count             <= 32'h00000000;
            cfg_word               <= 32'h00000000;
            cfg_word_valid         <= 1'b0;
        end
        else
        begin
            clk_d_ff       <= clk_s;
            cfg_word_valid <= 1'b0;
            if (!req_s)
            begin
                // request low: restart, 2 cycle sync well inside 600 ns
                state_ff              <= S_CLR;
                tmr_ff                <= 20'h00000;
                load_status_low_oe    <= 1'b1;
                load_complete_flag_oe <= 1'b1;
                init_done_oe          <= 1'b0;
                user_mode             <= 1'b0;
                load_error            <= 1'b0;
                word_count            <= 32'h00000000;
                rep_ff                <= 8'h00;
                opt_ff                <= 1'b0;
            end
            else
            begin
                case (state_ff)
                    S_POR, S_CLR:
                    begin
                        // status held low for the minimum pulse
                        tmr_ff <= tmr_ff + 20'h00001;
                        if (tmr_ff >= stat_cyc - 20'h00001)
                        begin
                            load_status_low_oe <= 1'b0;
                            state_ff           <= S_LOAD;
                            tmr_ff             <= 20'h00000;
                        end
                    end
                    S_LOAD:
                    begin
                        // status held low outside pauses loading
                        // released line reads high only after the sync delay
                        if (tmr_ff != 20'h00003)
                            tmr_ff <= tmr_ff + 20'h00001;
                        if (rise && stat_s)
                        begin
                            rep_ff <= last_rep ? 8'h00
                                               : rep_ff + 8'h01;
                            if (last_rep)
                            begin
                                cfg_word       <= word_in;
                                cfg_word_valid <= 1'b1;
                                if (word_count == 32'h00000000)
                                    opt_ff <= word_in[`FPL_OPT_INIT_BIT];
                                word_count <= word_count
                                              + 32'h00000001;
                                if (!load_error &&
                                    word_count + 32'h00000001 == image_words)
                                begin
                                    load_complete_flag_oe <= 1'b0;
                                    state_ff              <= S_DONE;
                                    tmr_ff                <= 20'h00000;
                                    fall_ff               <= 2'h0;
                                end
                            end
                        end
                        else if (!stat_s && !load_status_low_oe &&
                                 tmr_ff == 20'h00003)
                            load_error <= 1'b1;
                    end
                    S_DONE:
                    begin
                        // only falling edges count now; rising ones ignored
                        if (fall && fall_ff != 2'h2)
                            fall_ff <= fall_ff + 2'h1;
                        tmr_ff <= tmr_ff + 20'h00001;
                        // user mode waits for the completion line to read high
                        if (fall_ff == 2'h2 && done_s &&
                            tmr_ff >= um_cyc - 20'h00001)
                        begin
                            state_ff     <= S_USER;
                            user_mode    <= 1'b1;
                            init_done_oe <= opt_ff;
                        end
                    end
                    S_USER:
                    begin
                        user_mode <= 1'b1;
                    end
                    default:
                    begin
                        state_ff <= S_POR;
                    end
                endcase
            end
        end
    end
endmodule

// [fpl_regs.vh]
// Purpose: constants for the fast parallel configuration loader
// Assumes: ref_clk at 100 MHz (10 ns)
// Notes:   times in their own unit, cycle counts derived from them
`ifndef FPL_REGS_VH
`define FPL_REGS_VH
`define FPL_CLK_NS          10
`define FPL_T_CLEAR_NS      600
`define FPL_T_CLEAR_CYC     (`FPL_T_CLEAR_NS / `FPL_CLK_NS)
`define FPL_T_STAT_MIN_US   268
`define FPL_T_STAT_MAX_US   1506
`define FPL_T_STAT_MIN_CYC  ((`FPL_T_STAT_MIN_US * 1000) / `FPL_CLK_NS)
`define FPL_T_UM_MIN_US     175
`define FPL_T_UM_MAX_US     437
`define FPL_T_UM_MIN_CYC    ((`FPL_T_UM_MIN_US * 1000) / `FPL_CLK_NS)
`define FPL_RATIO_DEF       8'h01
`define FPL_WIDTH_X8        2'h0
`define FPL_WIDTH_X16       2'h1
`define FPL_WIDTH_X32       2'h2
`define FPL_OPT_INIT_BIT    0
`endif

// [fpl_sync.v]
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are levels
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
module fpl_sync #(
    parameter W = 1
)(
    // clock and reset
    input  wire         ref_clk,
    input  wire         rst_n,
    // data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
        end
        else
        begin
            s1_ff <= d;
            s2_ff <= s1_ff;
        end
    end

    assign q = s2_ff;
endmodule

// [fpl_loader_monitor.sv]
// Purpose: pin timing checks on the loader
// Assumes: single ref_clk domain
// Notes:   run counters keep long windows cheap
`timescale 1ns/1ns
module fpl_loader_chk #(
    parameter int STAT_CYC = 50,
    parameter int UM_CYC   = 30
)(
    // clock and reset
    input wire        ref_clk,
    input wire        rstn,
    // link
    input wire        reconfig_req_n,
    input wire        load_status_low_oe,
    input wire        load_complete_flag_oe,
    input wire        init_done_oe,
    // status
    input wire [31:0] image_words,
    input wire        user_mode,
    input wire [31:0] word_count,
    input wire        cfg_word_valid
);
    localparam int STAT_HI = STAT_CYC + 10;
    localparam int UM_LO   = UM_CYC - 2;
    localparam int UM_HI   = UM_CYC * 437 / 175;
    reg [31:0] stat_run_ff;
    reg [31:0] done_run_ff;
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stat_run_ff <= 32'h0;
            done_run_ff <= 32'h0;
        end
        else
        begin
            stat_run_ff <= load_status_low_oe ? stat_run_ff + 32'h1 : 32'h0;
            done_run_ff <= load_complete_flag_oe ? 32'h0 : done_run_ff + 32'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_req_drop;
        $fell(reconfig_req_n);
    endsequence
    sequence s_both_low;
        load_status_low_oe && load_complete_flag_oe;
    endsequence
    chk_req_clear: assert property (s_req_drop |-> ##[1:60] s_both_low)
        else $error("request drop not answered");
    chk_stat_min: assert property ($fell(load_status_low_oe) |->
        stat_run_ff >= STAT_CYC) else $error("status released early");
    chk_stat_max: assert property ($rose(reconfig_req_n) |->
        ##[1:STAT_HI] !load_status_low_oe) else $error("status held too long");
    chk_done_count: assert property ($fell(load_complete_flag_oe) |->
        word_count == image_words) else $error("done before full image");
    chk_clk_ignored: assert property ($past(!load_complete_flag_oe) &&
        !load_complete_flag_oe |-> !cfg_word_valid) else $error("word after done");
    chk_user_lines: assert property (user_mode |->
        !load_status_low_oe && !load_complete_flag_oe) else $error("user lines low");
    chk_um_delay: assert property ($rose(user_mode) |->
        done_run_ff >= UM_LO && done_run_ff <= UM_HI) else $error("user mode timing");
    chk_init_user: assert property (init_done_oe |-> user_mode)
        else $error("init pin outside user mode");
    chk_word_gate: assert property (load_status_low_oe |-> !cfg_word_valid)
        else $error("word taken while status low");
endmodule
bind fpl_loader fpl_loader_chk #(.STAT_CYC(STAT_CYC), .UM_CYC(UM_CYC)) i_chk (
    .ref_clk(ref_clk), .rstn(rstn), .reconfig_req_n(reconfig_req_n),
    .load_status_low_oe(load_status_low_oe), .init_done_oe(init_done_oe),
    .load_complete_flag_oe(load_complete_flag_oe), .image_words(image_words),
    .user_mode(user_mode), .word_count(word_count),
    .cfg_word_valid(cfg_word_valid));

// [fpl_host.sv]
// Purpose: behavioural configuration host
// Assumes: load clock 125 ns, still outside frames
// Notes:   data inverted after a frame, never left at last value
`timescale 1ns/1ns
module fpl_host (
    // link pins
    output logic        reconfig_req_n,
    output logic        load_clock,
    output logic [31:0] load_data
);
    initial
    begin
        reconfig_req_n = 1'b1;
        load_clock = 1'b0;
        load_data = 32'h0;
    end
    task automatic restart();
        #3; // keep pin changes off the ref_clk edge
        reconfig_req_n = 1'b0;
        #2500;
        reconfig_req_n = 1'b1;
    endtask
    task automatic word(input logic [31:0] w, input int r);
        #3;
        load_data = w;
        repeat (r)
        begin
            #62 load_clock = 1'b1;
            #63 load_clock = 1'b0;
        end
    endtask
    task automatic tail();
        repeat (2)
        begin
            #62 load_clock = 1'b1;
            #63 load_clock = 1'b0;
        end
        load_data = ~load_data;
    endtask
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the loader
// Assumes: short status and user-mode counts
// Notes:   status wire has a pull-up
`timescale 1ns/1ns
module tb_top;
    localparam int STAT_CYC = 50;
    logic        ref_clk;
    logic        rstn;
    logic [1:0]  bus_width;
    logic [7:0]  word_ratio;
    logic [31:0] image_words;
    logic [31:0] w;
    wire         req_n;
    wire         lclk;
    wire [31:0]  ldata;
    wire         st_oe;
    wire         cd_oe;
    wire         init_oe;
    wire         st_out;
    wire         cd_out;
    wire         init_out;
    wire         st_pin;
    wire         cd_pin;
    wire         init_pin;
    wire         load_error;
    logic        st_hold;
    wire         user_mode;
    wire [31:0]  word_count;
    wire [31:0]  cfg_word;
    int          err_total;
    int          cmp_count;
    // open-drain lines with pull-ups; st_hold plays an outside hold
    assign st_pin   = st_hold ? 1'b0 : (st_oe ? st_out : 1'b1);
    assign cd_pin   = cd_oe ? cd_out : 1'b1;
    assign init_pin = init_oe ? init_out : 1'b1;
    fpl_host i_fpl_host (.reconfig_req_n(req_n), .load_clock(lclk),
        .load_data(ldata));
    fpl_loader #(.STAT_CYC(STAT_CYC), .UM_CYC(30)) i_fpl_loader (
        .ref_clk(ref_clk), .rstn(rstn), .reconfig_req_n(req_n),
        .load_clock(lclk), .load_data(ldata), .load_status_low_in(st_pin),
        .load_status_low_out(st_out), .load_status_low_oe(st_oe),
        .load_complete_flag_in(cd_pin), .load_complete_flag_out(cd_out),
        .load_complete_flag_oe(cd_oe), .init_done_out(init_out),
        .init_done_oe(init_oe),
        .bus_width(bus_width), .word_ratio(word_ratio),
        .image_words(image_words), .user_mode(user_mode),
        .load_error(load_error),
        .word_count(word_count), .cfg_word(cfg_word), .cfg_word_valid());
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // user-mode wait when sel set, else status release
    task automatic await(input bit sel);
        int n;
        for (n = 0; n < 3000 && (sel ? user_mode !== 1'b1 : st_oe !== 1'b0); n++)
            @(posedge ref_clk);
        if (n == 3000)
        begin
            err_total++;
            end_of_test();
        end
    endtask
    initial
    begin
        rstn = 1'b0;
        st_hold = 1'b0;
        bus_width = 2'h0;
        word_ratio = 8'h01;
        image_words = 32'h3;
        err_total = 0;
        cmp_count = 0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        cmp("status_oe", 1'b1, st_oe);
        cmp("done_oe", 1'b1, cd_oe);
        cmp("pins_low", 2'h0, {st_pin, cd_pin});
        await(1'b0);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge ref_clk);
            bus_width <= k[1:0];
            word_ratio <= 8'(k == 0 ? 0 : k + 1); // 0 reads as 1
            i_fpl_host.restart();
            await(1'b0);
            #2000;
            for (int j = 0; j < 3; j++)
            begin
                w = 32'hA5C396E0 + j + (k != 1);
                i_fpl_host.word(w, k + 1);
                repeat (8) @(posedge ref_clk);
                cmp("count", j + 1, word_count);
                cmp("word", k == 0 ? w & 32'hFF : k == 1 ? w & 32'hFFFF : w, cfg_word);
                cmp("done_oe", j < 2, cd_oe);
            end
            i_fpl_host.tail();
            await(1'b1);
            cmp("init_oe", k != 1, init_oe);
            cmp("init_pin", k == 1, init_pin);
            cmp("count", 3, word_count);
            cmp("load_error", 0, load_error);
        end
        // status held low from outside: loading stalls and is flagged
        @(posedge ref_clk);
        i_fpl_host.restart();
        await(1'b0);
        st_hold <= 1'b1;
        repeat (8) @(posedge ref_clk);
        i_fpl_host.word(32'h0000005A, 1);
        repeat (8) @(posedge ref_clk);
        cmp("held_count", 0, word_count);
        cmp("load_error", 1, load_error);
        cmp("held_done_oe", 1, cd_oe);
        end_of_test();
    end
endmodule
